// ==== rtl/pss_defines.svh ====
// What this block does
// - Bits 15:14 read zero, writes ignored.
// - Bit 13 latches receive error, cleared by counter read.
// - Bit 12 latches polarity, cleared by 10BASE-T register read.
// - Bit 11 latches false carrier, cleared by counter read.
// - Bit 10 latch-low signal detect, resets zero.
// - Bit 9 latch-low descrambler lock, resets zero.
// - Bit 8 latches page received, cleared by expansion read.
// - Bit 7 interrupt pending, cleared by its read.
// - Bit 6 remote fault until basic status read.
// - Bit 5 mirrors jabber, summary read keeps it.
// - Bit 4 shows auto-negotiation complete.
// - Bit 3 shows loopback enabled.
// - Bit 2 shows duplex, one is full.
// - Bit 1 shows speed, one is 10 Mb/s.
// - Bit 0 mirrors link status, not read-cleared.
// - Read-only summary at 00C0h, resets 0000h.
// - Enabled, unmasked events raise the pending interrupt.
`ifndef PSS_DEFINES_SVH
`define PSS_DEFINES_SVH
`define PSS_ADDR_SUMMARY 8'hC0
`define PSS_ADDR_TENBASE 8'hB4
`define PSS_ADDR_ANEXP 8'h98
`define PSS_ADDR_BASIC_STAT 8'h84
`define PSS_ADDR_FCCNT 8'hD0
`define PSS_ADDR_RECNT 8'hD4
`define PSS_ADDR_IRQ_EN 8'hC4
`define PSS_ADDR_EVT_STAT 8'hE0
`define PSS_ADDR_EVT_MASK 8'hE4
`define PSS_SUMMARY_RESET 16'h0000
`define PSS_EVT_RESET 6'h00
`define PSS_MASK_RESET 6'h3F
`define PSS_NUM_EVT 6
`define PSS_NUM_SYNC 11
`endif

// ==== rtl/pss_pkg.sv ====
package pss_pkg;
   typedef struct packed {
      logic rx_error;
      logic false_carrier;
      logic polarity_inv;
      logic signal_detect;
      logic descr_lock;
      logic page_rx;
      logic remote_fault;
      logic jabber;
      logic an_complete;
      logic link_up;
      logic counter_half;
   } pss_status_type;
   typedef struct packed {
      logic loopback;
      logic full_duplex;
      logic speed10;
   } pss_mode_type;
   typedef struct packed {
      logic [7:0] addr;
      logic [15:0] wdata;
      logic wr;
      logic rd;
   } pss_bus_type;
endpackage

// ==== rtl/pss_sync.sv ====
`timescale 1ns/1ps
module pss_sync #(
   parameter int WIDTH = 1
)
(
   input wire logic mclk,
   input wire logic reset_n,
   input wire logic [WIDTH-1:0] d,
   output logic [WIDTH-1:0] q
);
   logic [WIDTH-1:0] meta_reg;
   // The first stage only feeds the second, so metastability cannot leak.
   always_ff @(posedge mclk)
   begin
      if (!reset_n)
      begin
         meta_reg <= '0;
         q <= '0;
      end
      else
      begin
         meta_reg <= d;
         q <= meta_reg;
      end
   end
endmodule

// ==== rtl/pss_latch_bit.sv ====
`timescale 1ns/1ps
module pss_latch_bit #(
   parameter bit LATCH_HIGH = 1'b1
)
(
   input wire logic mclk,
   input wire logic reset_n,
   input wire logic cond,
   input wire logic clear,
   output logic q
);
   // The event condition beats the clear in the same cycle.
   always_ff @(posedge mclk)
   begin
      if (!reset_n)
         q <= 1'b0;
      else if (LATCH_HIGH ? cond : !cond)
         q <= LATCH_HIGH;
      else if (clear)
         q <= LATCH_HIGH ? 1'b0 : cond;
   end
endmodule

// ==== rtl/pss_summary.sv ====
`timescale 1ns/1ps
`include "pss_defines.svh"
module pss_summary
(
   input wire logic mclk,
   input wire logic reset_n,
   input pss_pkg::pss_bus_type bus,
   input pss_pkg::pss_status_type status_in,
   input pss_pkg::pss_mode_type mode_in,
   output logic [15:0] rdata,
   output logic irq
);
   import pss_pkg::*;
   pss_status_type st;
   pss_mode_type md;
   pss_sync #(.WIDTH(`PSS_NUM_SYNC)) u_sync_st (
      .mclk(mclk),
      .reset_n(reset_n),
      .d(status_in),
      .q(st)
   );
   pss_sync #(.WIDTH(3)) u_sync_md (
      .mclk(mclk),
      .reset_n(reset_n),
      .d(mode_in),
      .q(md)
   );

   wire rd_sum = bus.rd && bus.addr == `PSS_ADDR_SUMMARY;
   wire rd_ten = bus.rd && bus.addr == `PSS_ADDR_TENBASE;
   wire rd_anx = bus.rd && bus.addr == `PSS_ADDR_ANEXP;
   wire rd_bms = bus.rd && bus.addr == `PSS_ADDR_BASIC_STAT;
   wire rd_fcc = bus.rd && bus.addr == `PSS_ADDR_FCCNT;
   wire rd_rec = bus.rd && bus.addr == `PSS_ADDR_RECNT;
   wire rd_est = bus.rd && bus.addr == `PSS_ADDR_EVT_STAT;
   wire wr_ien = bus.wr && bus.addr == `PSS_ADDR_IRQ_EN;
   wire wr_est = bus.wr && bus.addr == `PSS_ADDR_EVT_STAT;
   wire wr_msk = bus.wr && bus.addr == `PSS_ADDR_EVT_MASK;

   logic rxerr_q, fc_q, pol_q, sd_q, lock_q, page_q, rf_q, pend_q;
   logic link_d_reg, jab_d_reg, rf_d_reg, anc_d_reg, half_d_reg;
   logic irq_en_reg;
   logic [5:0] evt_reg, evt_next, mask_reg;
   logic [5:0] evt_raw;

   pss_latch_bit u_rxerr (.mclk(mclk), .reset_n(reset_n),
      .cond(st.rx_error), .clear(rd_rec), .q(rxerr_q));
   pss_latch_bit u_pol (.mclk(mclk), .reset_n(reset_n),
      .cond(st.polarity_inv), .clear(rd_ten), .q(pol_q));
   pss_latch_bit u_fc (.mclk(mclk), .reset_n(reset_n),
      .cond(st.false_carrier), .clear(rd_fcc), .q(fc_q));
   pss_latch_bit #(.LATCH_HIGH(1'b0)) u_sd (.mclk(mclk),
      .reset_n(reset_n), .cond(st.signal_detect), .clear(rd_sum),
      .q(sd_q));
   pss_latch_bit #(.LATCH_HIGH(1'b0)) u_lock (.mclk(mclk),
      .reset_n(reset_n), .cond(st.descr_lock), .clear(rd_sum),
      .q(lock_q));
   pss_latch_bit u_page (.mclk(mclk), .reset_n(reset_n),
      .cond(st.page_rx), .clear(rd_anx), .q(page_q));
   pss_latch_bit u_rf (.mclk(mclk), .reset_n(reset_n),
      .cond(st.remote_fault), .clear(rd_bms), .q(rf_q));

   // Events: link change, jabber, remote fault, aneg done, half full.
   assign evt_raw = {1'b0,
                     st.counter_half && !half_d_reg,
                     st.an_complete && !anc_d_reg,
                     st.remote_fault && !rf_d_reg,
                     st.jabber && !jab_d_reg,
                     st.link_up != link_d_reg};
   // Write one to clear; a new event in the same cycle stays set.
   assign evt_next = (evt_reg & ~(wr_est ? bus.wdata[5:0] : 6'h00))
                     | evt_raw;
   wire pend_set = irq_en_reg && |(evt_raw & ~mask_reg);
   // Pending stays set past a read that returned zero; the read that
   // returns one clears it unless a new event lands in that cycle.
   wire pend_clr = rd_sum && pend_q;

   always_ff @(posedge mclk)
   begin
      if (!reset_n)
      begin
         link_d_reg <= 1'b0;
         jab_d_reg <= 1'b0;
         rf_d_reg <= 1'b0;
         anc_d_reg <= 1'b0;
         half_d_reg <= 1'b0;
         irq_en_reg <= 1'b0;
         evt_reg <= `PSS_EVT_RESET;
         mask_reg <= `PSS_MASK_RESET;
         pend_q <= 1'b0;
      end
      else
      begin
         link_d_reg <= st.link_up;
         jab_d_reg <= st.jabber;
         rf_d_reg <= st.remote_fault;
         anc_d_reg <= st.an_complete;
         half_d_reg <= st.counter_half;
         evt_reg <= evt_next;
         if (wr_ien)
            irq_en_reg <= bus.wdata[1];
         if (wr_msk)
            mask_reg <= bus.wdata[5:0];
         if (pend_set)
            pend_q <= 1'b1;
         else if (pend_clr)
            pend_q <= 1'b0;
      end
   end

   // Bits 15:14 are constant zero and no write reaches this word.
   wire [15:0] sum_word = {2'b00, rxerr_q, pol_q, fc_q, sd_q, lock_q,
      page_q, pend_q, rf_q, st.jabber, st.an_complete, md.loopback,
      md.full_duplex, md.speed10, st.link_up};
   wire [15:0] read_mux = rd_sum ? sum_word :
                          rd_est ? {10'h000, evt_reg} :
                          16'h0000;

   always_ff @(posedge mclk)
   begin
      if (!reset_n)
      begin
         rdata <= `PSS_SUMMARY_RESET;
         irq <= 1'b0;
      end
      else
      begin
         rdata <= read_mux;
         irq <= |(evt_next & ~mask_reg);
      end
   end

   property p_pend_clear;
      @(posedge mclk) disable iff (!reset_n)
      (rd_sum && pend_q && !pend_set) |=> !pend_q;
   endproperty
   a_pend_clear: assert property (p_pend_clear)
      else $error("pending bit survived its read");
   property p_rsvd_zero;
      @(posedge mclk) disable iff (!reset_n)
      $past(rd_sum) |-> rdata[15:14] == 2'b00;
   endproperty
   a_rsvd_zero: assert property (p_rsvd_zero)
      else $error("reserved bits read nonzero");
   property p_rxerr_hold;
      @(posedge mclk) disable iff (!reset_n)
      (rxerr_q && !rd_rec) |=> rxerr_q;
   endproperty
   a_rxerr_hold: assert property (p_rxerr_hold)
      else $error("receive error latch dropped without counter read");
   property p_fc_set;
      @(posedge mclk) disable iff (!reset_n)
      st.false_carrier |=> fc_q;
   endproperty
   a_fc_set: assert property (p_fc_set)
      else $error("false carrier latch missed event");
   property p_sd_low;
      @(posedge mclk) disable iff (!reset_n)
      !st.signal_detect |=> !sd_q;
   endproperty
   a_sd_low: assert property (p_sd_low)
      else $error("signal detect did not latch low");
   property p_rf_hold;
      @(posedge mclk) disable iff (!reset_n)
      (rf_q && !rd_bms) |=> rf_q;
   endproperty
   a_rf_hold: assert property (p_rf_hold)
      else $error("remote fault cleared early");
   property p_page_keep;
      @(posedge mclk) disable iff (!reset_n)
      (page_q && rd_sum && !rd_anx) |=> page_q;
   endproperty
   a_page_keep: assert property (p_page_keep)
      else $error("page bit cleared by summary read");
   property p_link_read;
      @(posedge mclk) disable iff (!reset_n)
      rd_sum |=> rdata[0] == $past(st.link_up) && rdata[4] ==
         $past(st.an_complete);
   endproperty
   a_link_read: assert property (p_link_read)
      else $error("link or aneg bit read wrong");
endmodule

// ==== verification/pss_summary_test.sv ====
`timescale 1ns/1ps
`include "pss_defines.svh"
module pss_summary_test;
   import pss_pkg::*;
   logic mclk = 1'b0;
   logic reset_n = 1'b0;
   pss_bus_type bus = '0;
   pss_status_type status_in = '0;
   pss_mode_type mode_in = '0;
   logic [15:0] rdata;
   logic irq;
   logic [15:0] d;
   logic [15:0] e;
   logic [7:0] clr_addr [5] = '{8'hD4, 8'hB4, 8'hD0, 8'h98, 8'h84};
   logic [15:0] clr_mask [5] = '{16'h2000, 16'h1000, 16'h0800, 16'h0100,
                                 16'h0040};
   int evt_src [5] = '{1, 3, 4, 2, 0};
   int n_mismatch = 0;
   int checks = 0;

   pss_summary i_pss_summary (
      .mclk(mclk),
      .reset_n(reset_n),
      .bus(bus),
      .status_in(status_in),
      .mode_in(mode_in),
      .rdata(rdata),
      .irq(irq)
   );

   always #25 mclk = ~mclk;

   task automatic tick(input int n);
      repeat (n) @(posedge mclk);
   endtask

   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      checks = checks + 1;
      if (seen !== exp)
      begin
         n_mismatch = n_mismatch + 1;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [15:0] v);
      @(posedge mclk);
      bus.addr <= a;
      bus.wdata <= v;
      bus.wr <= 1'b1;
      @(posedge mclk);
      bus.wr <= 1'b0;
   endtask

   // Read data stand only in the cycle after the strobe, so sample there.
   task automatic rd(input logic [7:0] a, output logic [15:0] v);
      @(posedge mclk);
      bus.addr <= a;
      bus.rd <= 1'b1;
      @(posedge mclk);
      bus.rd <= 1'b0;
      #1 v = rdata;
   endtask

   task automatic test_done;
      if (n_mismatch == 0 && checks > 0)
      begin
         $display("TEST PASSED");
      end
      else
      begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   initial
   begin
      tick(3);
      reset_n <= 1'b1;
      tick(3);
      rd(`PSS_ADDR_SUMMARY, d);
      chk(d, `PSS_SUMMARY_RESET);
      chk({15'h0000, irq}, 16'h0000);
      rd(8'h10, d);
      chk(d, 16'h0000);
      wr(`PSS_ADDR_SUMMARY, 16'hFFFF);
      rd(`PSS_ADDR_SUMMARY, d);
      chk(d, 16'h0000);
      tick(1);
      mode_in <= 3'b111;
      status_in.link_up <= 1'b1;
      status_in.an_complete <= 1'b1;
      status_in.jabber <= 1'b1;
      status_in.signal_detect <= 1'b1;
      status_in.descr_lock <= 1'b1;
      tick(6);
      // Latch-low bits still show the low seen before this read.
      rd(`PSS_ADDR_SUMMARY, d);
      chk(d, 16'h003F);
      rd(`PSS_ADDR_SUMMARY, d);
      chk(d, 16'h063F);
      tick(1);
      status_in.signal_detect <= 1'b0;
      tick(2);
      status_in.signal_detect <= 1'b1;
      tick(6);
      rd(`PSS_ADDR_SUMMARY, d);
      chk(d, 16'h023F);
      rd(`PSS_ADDR_SUMMARY, d);
      chk(d, 16'h063F);
      tick(1);
      // Pulse only the latched-high sources; the latch-low inputs stay up.
      status_in.rx_error <= 1'b1;
      status_in.false_carrier <= 1'b1;
      status_in.polarity_inv <= 1'b1;
      status_in.page_rx <= 1'b1;
      status_in.remote_fault <= 1'b1;
      tick(2);
      status_in.rx_error <= 1'b0;
      status_in.false_carrier <= 1'b0;
      status_in.polarity_inv <= 1'b0;
      status_in.page_rx <= 1'b0;
      status_in.remote_fault <= 1'b0;
      tick(6);
      e = 16'h3F7F;
      rd(`PSS_ADDR_SUMMARY, d);
      chk(d, e);
      for (int i = 0; i < 5; i++)
      begin
         rd(clr_addr[i], d);
         e = e & ~clr_mask[i];
         rd(`PSS_ADDR_SUMMARY, d);
         chk(d, e);
      end
      tick(1);
      status_in[4:0] <= 5'h00;
      tick(6);
      wr(`PSS_ADDR_IRQ_EN, 16'h0002);
      wr(`PSS_ADDR_EVT_MASK, 16'h0000);
      wr(`PSS_ADDR_EVT_STAT, 16'h003F);
      tick(2);
      chk({15'h0000, irq}, 16'h0000);
      for (int i = 0; i < 5; i++)
      begin
         tick(1);
         status_in[evt_src[i]] <= 1'b1;
         tick(8);
         chk({15'h0000, irq}, 16'h0001);
         wr(`PSS_ADDR_EVT_MASK, 16'h0001 << i);
         tick(2);
         chk({15'h0000, irq}, 16'h0000);
         wr(`PSS_ADDR_EVT_MASK, 16'h0000);
         tick(2);
         chk({15'h0000, irq}, 16'h0001);
         wr(`PSS_ADDR_EVT_STAT, 16'h0001 << i);
         tick(2);
         chk({15'h0000, irq}, 16'h0000);
      end
      rd(`PSS_ADDR_SUMMARY, d);
      chk(d & 16'h0080, 16'h0080);
      rd(`PSS_ADDR_SUMMARY, d);
      chk(d & 16'h0080, 16'h0000);
      test_done();
   end
endmodule
